// File: rtl/isosus_scheduler.v
// Isochronous split microframe scheduler with an AXI4-Lite register slave.
//
// Notes on behaviour
// (R1) Store received byte count per microframe only if start split ran there.
// (R2) Software sets complete-split mask bits; hardware clears each once processed.
// (R3) Issue complete split where mask bit set; only for IN, ignored for OUT.
// (R4) Mask bit position n selects microframe n for both masks.
// (R5) Keep eight 3-bit outcome fields, one per microframe.
// (R6) Outcome bit 0 error, bit 1 babble IN only, bit 2 underrun OUT only.
// (R7) Software sets start-split mask bits; hardware clears each after processing.
// (R8) OUT: on frame match check start-split bit before sending in that microframe.
// (R9) Software sets IN start-split bits only for microframes 0 to 3.
// (R10) Target frame is uframe field bits 7 to 3, compared with bus frame.
// (R11) Summary error and babble flags mirror outcome bits 0 and 1.
`include "isosus_defs.vh"

module isosus_scheduler (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // AXI4-Lite write address and data
    input wire [5:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    // AXI4-Lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read
    input wire [5:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // Bus timing from the frame generator
    input wire uframe_start,
    input wire [2:0] uframe_index,
    input wire [4:0] bus_frame_num,
    // Split requests toward the transaction engine
    output reg start_split_req,
    output reg complete_split_req,
    output reg [2:0] split_uframe,
    // Transaction results
    input wire result_valid,
    input wire [2:0] result_uframe,
    input wire [7:0] result_bytes,
    input wire result_err,
    input wire result_babble,
    input wire result_underrun,
    // Interrupt
    output reg irq
);

    // ======================================================================
    // Helpers

    // One-hot select of a microframe.
    function [7:0] uf_bit;
        input [2:0] n;
        begin
            uf_bit = 8'h01 << n;
        end
    endfunction

    // ======================================================================
    // State

    reg [1:0] ctrl_reg;
    reg [7:0] uframe_field_reg;
    reg [7:0] start_split_uframe_mask_reg;
    reg [7:0] complete_split_uframe_mask_reg;
    reg [7:0] ss_done_reg;
    reg [23:0] outcome_reg;
    reg [7:0] byte_count_reg [0:7];
    reg [3:0] irq_status_reg;
    reg [3:0] irq_mask_reg;
    reg [5:0] aw_addr_reg;
    reg aw_have_reg;
    reg [31:0] w_data_reg;
    reg [3:0] w_strb_reg;
    reg w_have_reg;
    integer i;
    integer k;

    wire is_in = ctrl_reg[`ISOSUS_CTRL_IN_TOKEN];
    wire enabled = ctrl_reg[`ISOSUS_CTRL_ENABLE];
    wire [7:0] cur_bit = uf_bit(uframe_index);
    wire [7:0] res_bit = uf_bit(result_uframe);
    wire frame_match = uframe_field_reg[`ISOSUS_FRAME_HI:`ISOSUS_FRAME_LO] == bus_frame_num; // R10
    wire slot_live = uframe_start && enabled && frame_match;
    wire do_ss = slot_live && |(start_split_uframe_mask_reg & cur_bit); // R4 R8
    wire do_cs = slot_live && is_in && |(complete_split_uframe_mask_reg & cur_bit); // R3 R4
    wire do_write = aw_have_reg && w_have_reg && !s_axi_bvalid;
    wire wr_lane0 = do_write && w_strb_reg[0];

    // ======================================================================
    // Split issue and mask clearing

    // Masks are cleared in the microframe that consumes them; a software set
    // in the same cycle wins so that a fresh request is never dropped.
    reg [7:0] ss_set;
    reg [7:0] cs_set;
    always @* begin
        ss_set = 8'h00;
        cs_set = 8'h00;
        if (wr_lane0 && aw_addr_reg == `ISOSUS_OFF_SS_MASK) begin
            ss_set = w_data_reg[7:0];
        end
        if (wr_lane0 && aw_addr_reg == `ISOSUS_OFF_CS_MASK) begin
            cs_set = w_data_reg[7:0];
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            start_split_uframe_mask_reg <= `ISOSUS_RST_MASK;
            complete_split_uframe_mask_reg <= `ISOSUS_RST_MASK;
            ss_done_reg <= `ISOSUS_RST_MASK;
            start_split_req <= 1'b0;
            complete_split_req <= 1'b0;
            split_uframe <= 3'h0;
        end else begin
            start_split_req <= do_ss;
            complete_split_req <= do_cs;
            if (uframe_start) begin
                split_uframe <= uframe_index;
            end
            start_split_uframe_mask_reg <= (start_split_uframe_mask_reg &
                ~(do_ss ? cur_bit : 8'h00)) | ss_set; // R7
            complete_split_uframe_mask_reg <= (complete_split_uframe_mask_reg &
                ~(do_cs ? cur_bit : 8'h00)) | cs_set; // R2
            // Remember where a start split ran, so its byte count may land.
            ss_done_reg <= (ss_done_reg & ~(result_valid ? res_bit : 8'h00)) |
                (do_ss ? cur_bit : 8'h00);
        end
    end

    // ======================================================================
    // Result capture

    // Babble is only meaningful for IN and underrun only for OUT, so each is
    // masked by the token direction before it is stored.
    always @(posedge aclk) begin
        if (!aresetn) begin
            outcome_reg <= `ISOSUS_RST_OUTCOME;
            for (i = 0; i < 8; i = i + 1) begin
                byte_count_reg[i] <= 8'h00;
            end
        end else if (result_valid) begin
            outcome_reg[result_uframe * 3 + `ISOSUS_OUT_ERR] <= result_err; // R5 R6
            outcome_reg[result_uframe * 3 + `ISOSUS_OUT_BABBLE] <= result_babble && is_in; // R6
            outcome_reg[result_uframe * 3 + `ISOSUS_OUT_UNDERRUN] <=
                result_underrun && !is_in; // R6
            if (|(ss_done_reg & res_bit)) begin
                byte_count_reg[result_uframe] <= result_bytes; // R1
            end
        end
    end

    // Summary flags gather one bit position from all eight outcome fields.
    reg sum_err;
    reg sum_babble;
    always @* begin
        sum_err = 1'b0;
        sum_babble = 1'b0;
        // A loop variable of its own keeps this process from sharing a driver.
        for (k = 0; k < 8; k = k + 1) begin
            sum_err = sum_err | outcome_reg[k * 3 + `ISOSUS_OUT_ERR]; // R11
            sum_babble = sum_babble | outcome_reg[k * 3 + `ISOSUS_OUT_BABBLE]; // R11
        end
    end

    // ======================================================================
    // Interrupts

    wire [3:0] irq_events = result_valid ? {result_underrun && !is_in,
        result_babble && is_in, result_err, 1'b1} : 4'h0;
    wire [3:0] irq_clear = (wr_lane0 && aw_addr_reg == `ISOSUS_OFF_IRQ_STATUS) ?
        w_data_reg[3:0] : 4'h0;

    // Write-one-to-clear status; an event in the clearing cycle still sticks.
    always @(posedge aclk) begin
        if (!aresetn) begin
            irq_status_reg <= `ISOSUS_RST_IRQ;
            irq <= 1'b0;
        end else begin
            irq_status_reg <= (irq_status_reg & ~irq_clear) | irq_events;
            irq <= |(((irq_status_reg & ~irq_clear) | irq_events) & irq_mask_reg);
        end
    end

    // ======================================================================
    // AXI4-Lite write channel

    // Address and data are held separately so either may come first.
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            aw_addr_reg <= 6'h00;
            w_data_reg <= 32'h00000000;
            w_strb_reg <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `ISOSUS_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end else if (do_write) begin
                aw_have_reg <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end else if (do_write) begin
                w_have_reg <= 1'b0;
            end
            s_axi_awready <= !aw_have_reg && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready <= !w_have_reg && !(s_axi_wvalid && s_axi_wready);
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                case (aw_addr_reg)
                    `ISOSUS_OFF_CTRL, `ISOSUS_OFF_UFRAME, `ISOSUS_OFF_SS_MASK,
                    `ISOSUS_OFF_CS_MASK, `ISOSUS_OFF_IRQ_STATUS,
                    `ISOSUS_OFF_IRQ_MASK: begin
                        s_axi_bresp <= `ISOSUS_RESP_OKAY;
                    end
                    default: begin
                        s_axi_bresp <= `ISOSUS_RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Plain read-write registers; only byte lane 0 carries their bits.
    always @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg <= `ISOSUS_RST_CTRL;
            uframe_field_reg <= 8'h00;
            irq_mask_reg <= `ISOSUS_RST_IRQ;
        end else if (wr_lane0) begin
            if (aw_addr_reg == `ISOSUS_OFF_CTRL) begin
                ctrl_reg <= w_data_reg[1:0];
            end
            if (aw_addr_reg == `ISOSUS_OFF_UFRAME) begin
                uframe_field_reg <= w_data_reg[7:0];
            end
            if (aw_addr_reg == `ISOSUS_OFF_IRQ_MASK) begin
                irq_mask_reg <= w_data_reg[3:0];
            end
        end
    end

    // ======================================================================
    // AXI4-Lite read channel

    reg [31:0] rd_mux;
    reg rd_hit;
    always @* begin
        rd_hit = 1'b1;
        rd_mux = 32'h00000000;
        case (s_axi_araddr)
            `ISOSUS_OFF_CTRL: rd_mux = {30'h00000000, ctrl_reg};
            `ISOSUS_OFF_UFRAME: rd_mux = {24'h000000, uframe_field_reg};
            `ISOSUS_OFF_SS_MASK: rd_mux = {24'h000000, start_split_uframe_mask_reg};
            `ISOSUS_OFF_CS_MASK: rd_mux = {24'h000000, complete_split_uframe_mask_reg};
            `ISOSUS_OFF_OUTCOME: rd_mux = {8'h00, outcome_reg};
            `ISOSUS_OFF_BYTES_LO: begin
                rd_mux = {byte_count_reg[3], byte_count_reg[2],
                    byte_count_reg[1], byte_count_reg[0]};
            end
            `ISOSUS_OFF_BYTES_HI: begin
                rd_mux = {byte_count_reg[7], byte_count_reg[6],
                    byte_count_reg[5], byte_count_reg[4]};
            end
            `ISOSUS_OFF_SUMMARY: rd_mux = {30'h00000000, sum_babble, sum_err};
            `ISOSUS_OFF_IRQ_STATUS: rd_mux = {28'h0000000, irq_status_reg};
            `ISOSUS_OFF_IRQ_MASK: rd_mux = {28'h0000000, irq_mask_reg};
            default: rd_hit = 1'b0;
        endcase
    end

    // The read data is sampled at the address handshake, on the same edge
    // that rvalid rises, so the answer is a snapshot of that edge.
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `ISOSUS_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_mux;
                s_axi_rresp <= rd_hit ? `ISOSUS_RESP_OKAY : `ISOSUS_RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule

// File: rtl/isosus_defs.vh
// Constants for the isochronous split microframe scheduler.
`ifndef ISOSUS_DEFS_VH
`define ISOSUS_DEFS_VH

// ==========================================================================
// Register byte offsets
`define ISOSUS_OFF_CTRL 6'h00
`define ISOSUS_OFF_UFRAME 6'h04
`define ISOSUS_OFF_SS_MASK 6'h08
`define ISOSUS_OFF_CS_MASK 6'h0c
`define ISOSUS_OFF_OUTCOME 6'h10
`define ISOSUS_OFF_BYTES_LO 6'h14
`define ISOSUS_OFF_BYTES_HI 6'h18
`define ISOSUS_OFF_SUMMARY 6'h1c
`define ISOSUS_OFF_IRQ_STATUS 6'h20
`define ISOSUS_OFF_IRQ_MASK 6'h24

// ==========================================================================
// Field positions
`define ISOSUS_CTRL_ENABLE 0
`define ISOSUS_CTRL_IN_TOKEN 1
`define ISOSUS_FRAME_HI 7
`define ISOSUS_FRAME_LO 3
`define ISOSUS_OUT_ERR 0
`define ISOSUS_OUT_BABBLE 1
`define ISOSUS_OUT_UNDERRUN 2
`define ISOSUS_EV_DONE 0
`define ISOSUS_EV_ERR 1
`define ISOSUS_EV_BABBLE 2
`define ISOSUS_EV_UNDERRUN 3

// ==========================================================================
// Reset values and bus answers
`define ISOSUS_RST_CTRL 2'h0
`define ISOSUS_RST_MASK 8'h00
`define ISOSUS_RST_OUTCOME 24'h000000
`define ISOSUS_RST_IRQ 4'h0
`define ISOSUS_RESP_OKAY 2'h0
`define ISOSUS_RESP_SLVERR 2'h2

`endif

// File: verif/isosus_sched_sva.sv
// Port checker for the isochronous split microframe scheduler.
// ==========================================
// Checker
module isosus_sched_sva (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Bus handshakes
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    // Microframe timing and split requests
    input wire uframe_start,
    input wire [2:0] uframe_index,
    input wire start_split_req,
    input wire complete_split_req,
    input wire [2:0] split_uframe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // A write is answered exactly two edges after both beats are taken together.
    sequence wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence wr_answer;
        !s_axi_bvalid ##1 s_axi_bvalid;
    endsequence
    wr_timing_a: assert property (wr_take |=> wr_answer)
        else $error("write response out of time");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    rd_timing_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data out of time");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address accepted while data pending");
    // Split requests only follow a microframe start and name its index.
    ss_after_sof_a: assert property (start_split_req |-> $past(uframe_start))
        else $error("start split without microframe start");
    ss_uframe_a: assert property (start_split_req |-> split_uframe == $past(uframe_index))
        else $error("start split in wrong microframe");
    cs_after_sof_a: assert property (complete_split_req |-> $past(uframe_start))
        else $error("complete split without microframe start");
    cs_uframe_a: assert property (complete_split_req |-> split_uframe == $past(uframe_index))
        else $error("complete split in wrong microframe");
endmodule

bind isosus_scheduler isosus_sched_sva i_sva (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .uframe_start(uframe_start), .uframe_index(uframe_index),
    .start_split_req(start_split_req), .complete_split_req(complete_split_req),
    .split_uframe(split_uframe)
);

// File: verif/isosus_fs_device.sv
// Behavioural full-speed device behind the hub that answers split requests.
module isosus_fs_device (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Split requests from the scheduler
    input wire start_split_req,
    input wire complete_split_req,
    input wire [2:0] split_uframe,
    // Bench controls: stray result, slow reply and result contents
    input wire kick,
    input wire slow,
    input wire [3:0] byte_hi,
    input wire f_err,
    input wire f_bab,
    input wire f_und,
    // Transaction result
    output logic result_valid,
    output wire [2:0] result_uframe,
    output wire [7:0] result_bytes,
    output wire result_err,
    output wire result_babble,
    output wire result_underrun
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] cnt = 3'h0;
    logic [2:0] uf = 3'h0;
    // A request, or a commanded stray result, starts a prompt or slow reply.
    always @(posedge aclk) begin
        result_valid <= 1'b0;
        if (!aresetn) begin
            cnt <= 3'h0;
        end else if (start_split_req || complete_split_req || kick) begin
            cnt <= slow ? 3'h6 : 3'h1;
            uf <= split_uframe;
        end else if (cnt != 3'h0) begin
            cnt <= cnt - 3'h1;
            result_valid <= (cnt == 3'h1);
        end
    end
    // Outside a result the lines show inverted values, so nothing stale looks valid.
    assign result_uframe = result_valid ? uf : ~uf;
    assign result_bytes = result_valid ? {byte_hi, 1'b0, uf} : ~{byte_hi, 1'b0, uf};
    assign result_err = result_valid ? f_err : ~f_err;
    assign result_babble = result_valid ? f_bab : ~f_bab;
    assign result_underrun = result_valid ? f_und : ~f_und;
endmodule

// File: verif/test_iso_split_uframe_scheduler.sv
// Self-checking bench for the isochronous split microframe scheduler.
`include "isosus_defs.vh"
module test_iso_split_uframe_scheduler;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid, ss_req, cs_req, irq, res_v, r_e, r_b, r_u;
    logic sof = 0, kick = 0, slow = 0, f_err = 0, f_bab = 0, f_und = 0;
    logic [5:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata;
    logic [1:0] bresp, rresp;
    logic [2:0] uf_idx = 0, split_uf, res_uf;
    logic [4:0] bus_frame = 0;
    logic [3:0] byte_hi = 0, wstrb = 4'hf;
    logic [7:0] res_bytes;
    int mismatches = 0, n_checks = 0, cyc = 0;
    // ==========================================
    // Clock, design and far-side model
    always #5 aclk = ~aclk;
    isosus_scheduler i_isosus_scheduler (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .uframe_start(sof), .uframe_index(uf_idx), .bus_frame_num(bus_frame),
        .start_split_req(ss_req), .complete_split_req(cs_req), .split_uframe(split_uf),
        .result_valid(res_v), .result_uframe(res_uf), .result_bytes(res_bytes),
        .result_err(r_e), .result_babble(r_b), .result_underrun(r_u), .irq(irq));
    isosus_fs_device i_isosus_fs_device (.aclk(aclk), .aresetn(aresetn),
        .start_split_req(ss_req), .complete_split_req(cs_req), .split_uframe(split_uf),
        .kick(kick), .slow(slow), .byte_hi(byte_hi), .f_err(f_err), .f_bab(f_bab),
        .f_und(f_und), .result_valid(res_v), .result_uframe(res_uf),
        .result_bytes(res_bytes), .result_err(r_e), .result_babble(r_b), .result_underrun(r_u));
    // ==========================================
    // Checking, bus and microframe tasks
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask
    // Address and data go out together; a late response ready exercises the hold.
    task automatic wr(input logic [5:0] a, input logic [31:0] d, input int lag,
        output logic [1:0] r);
        bit ad = 0, dd = 0;
        awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1;
        while (!(ad && dd)) begin
            @(posedge aclk);
            if (awready && !ad) begin ad = 1; awvalid <= 0; end
            if (wready && !dd) begin dd = 1; wvalid <= 0; end
        end
        repeat (lag) @(posedge aclk);
        bready <= 1;
        do @(posedge aclk); while (!bvalid);
        r = bresp;
        bready <= 0;
    endtask
    task automatic rd(input logic [5:0] a, input int lag, output logic [31:0] d,
        output logic [1:0] r);
        araddr <= a; arvalid <= 1;
        do @(posedge aclk); while (!arready);
        arvalid <= 0;
        repeat (lag) @(posedge aclk);
        rready <= 1;
        do @(posedge aclk); while (!rvalid);
        d = rdata; r = rresp;
        rready <= 0;
    endtask
    task automatic rdc(input logic [5:0] a, input logic [31:0] e);
        logic [31:0] d; logic [1:0] r;
        rd(a, 0, d, r);
        chk("register", d, e);
    endtask
    // One microframe: pulse its start, sample the request pulses, optionally kick a stray result.
    task automatic step(input logic [2:0] i, input logic k, output logic ss, output logic cs);
        uf_idx <= i; sof <= 1;
        @(posedge aclk); sof <= 0;
        @(posedge aclk); ss = ss_req; cs = cs_req; kick <= k;
        @(posedge aclk); kick <= 0;
        repeat (10) @(posedge aclk);
    endtask
    // ==========================================
    // Scenarios
    task automatic t_regs();
        logic [31:0] d; logic [1:0] r;
        for (int i = 0; i < 10; i++) if (i != 5 && i != 6) rdc(6'(4 * i), 32'h0);
        rd(6'h28, 3, d, r);
        chk("unmapped data", d, 32'h0);
        chk("unmapped read", {30'h0, r}, {30'h0, `ISOSUS_RESP_SLVERR});
        wr(6'h2c, 32'hff, 3, r);
        chk("unmapped write", {30'h0, r}, {30'h0, `ISOSUS_RESP_SLVERR});
        // A write without byte lane 0 must leave the control bits alone.
        wstrb <= 4'he;
        wr(`ISOSUS_OFF_CTRL, 32'h3, 0, r);
        wstrb <= 4'hf;
        rdc(`ISOSUS_OFF_CTRL, 32'h0);
        wr(`ISOSUS_OFF_OUTCOME, 32'hffffff, 0, r);
        rdc(`ISOSUS_OFF_OUTCOME, 32'h0);
        $display("register test done");
    endtask
    task automatic t_out();
        logic ss, cs; logic [1:0] r;
        byte_hi <= 4'h3; f_err <= 1; f_bab <= 1; f_und <= 1; bus_frame <= 5'h05;
        wr(`ISOSUS_OFF_UFRAME, 32'h28, 0, r);
        wr(`ISOSUS_OFF_SS_MASK, 32'h05, 0, r);
        wr(`ISOSUS_OFF_CS_MASK, 32'h04, 0, r);
        // While disabled a matching frame must not start anything.
        step(3'h0, 1'b0, ss, cs);
        chk("disabled", {30'h0, ss, cs}, 32'h0);
        wr(`ISOSUS_OFF_CTRL, 32'h1, 0, r);
        for (int i = 0; i < 8; i++) begin
            step(3'(i), i == 3, ss, cs);
            chk("out splits", {30'h0, ss, cs}, {30'h0, i == 0 || i == 2, 1'b0});
        end
        rdc(`ISOSUS_OFF_SS_MASK, 32'h0);
        rdc(`ISOSUS_OFF_CS_MASK, 32'h4);
        rdc(`ISOSUS_OFF_OUTCOME, 32'hb45);
        rdc(`ISOSUS_OFF_BYTES_LO, 32'h0032_0030);
        rdc(`ISOSUS_OFF_SUMMARY, 32'h1);
        rdc(`ISOSUS_OFF_IRQ_STATUS, 32'hb);
        chk("irq masked", {31'h0, irq}, 32'h0);
        wr(`ISOSUS_OFF_IRQ_MASK, 32'h1, 0, r);
        repeat (2) @(posedge aclk);
        chk("irq raised", {31'h0, irq}, 32'h1);
        wr(`ISOSUS_OFF_IRQ_STATUS, 32'hf, 0, r);
        repeat (2) @(posedge aclk);
        chk("irq cleared", {31'h0, irq}, 32'h0);
        rdc(`ISOSUS_OFF_IRQ_STATUS, 32'h0);
        $display("out test done");
    endtask
    task automatic t_in();
        logic ss, cs; logic [1:0] r;
        byte_hi <= 4'h7; f_err <= 0; slow <= 1; bus_frame <= 5'h06;
        wr(`ISOSUS_OFF_SS_MASK, 32'h01, 0, r);
        wr(`ISOSUS_OFF_CS_MASK, 32'h04, 0, r);
        wr(`ISOSUS_OFF_CTRL, 32'h3, 0, r);
        step(3'h0, 1'b0, ss, cs);
        chk("frame mismatch", {30'h0, ss, cs}, 32'h0);
        rdc(`ISOSUS_OFF_SS_MASK, 32'h1);
        bus_frame <= 5'h05;
        for (int i = 0; i < 4; i++) begin
            step(3'(i), 1'b0, ss, cs);
            chk("in splits", {30'h0, ss, cs}, {30'h0, i == 0, i == 2});
        end
        rdc(`ISOSUS_OFF_SS_MASK, 32'h0);
        rdc(`ISOSUS_OFF_CS_MASK, 32'h0);
        rdc(`ISOSUS_OFF_OUTCOME, 32'ha82);
        rdc(`ISOSUS_OFF_BYTES_LO, 32'h0032_0070);
        rdc(`ISOSUS_OFF_SUMMARY, 32'h3);
        rdc(`ISOSUS_OFF_IRQ_STATUS, 32'h5);
        $display("in test done");
    endtask
    // ==========================================
    // Main sequence and hang guard
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 4000) begin
            mismatches++;
            end_of_test();
        end
    end
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_regs();
        t_out();
        t_in();
        end_of_test();
    end
endmodule
